// ---- logic/twe_pkg.sv ----
// Shared constants for the two-wire framing ends
package twe_pkg;
    // Word and acknowledge framing
    localparam int WORD_BITS = 8;
    localparam logic [3:0] ACK_SLOT = 4'h8;
    localparam logic [3:0] BIT_LAST = 4'h7;
    localparam logic [3:0] BIT_ZERO = 4'h0;
    localparam logic [3:0] RECOVER_CYCLES = 4'h9;
    // Clock rate and self-timed write interval
    localparam int CLK_PERIOD_NS = 10;
    localparam int SELF_TIMED_WRITE_INTERVAL_MS = 10;
    localparam int WRITE_CYCLES =
        SELF_TIMED_WRITE_INTERVAL_MS * 1000000 / CLK_PERIOD_NS;
    // Controller serial clock divider, half period in clock cycles minus one
    localparam logic [7:0] HALF_PERIOD = 8'h1F;
    localparam logic [7:0] QUARTER_PERIOD = 8'h0F;
    localparam logic [7:0] CNT_ZERO = 8'h00;
    localparam logic [7:0] CNT_ONE = 8'h01;
    localparam logic [23:0] WR_ZERO = 24'h000000;
    localparam logic [23:0] WR_ONE = 24'h000001;
endpackage

// ---- logic/twe_bus_if.sv ----
// Interface joining controller and target over the two-wire bus
`timescale 1ns/1ps
interface twe_bus_if;
    logic scl;
    logic sda_ctl_oe;
    logic sda_dev_oe;
    logic sda;
    // Open drain: pulled high unless someone drives low
    assign sda = ~(sda_ctl_oe | sda_dev_oe);
    modport ctl (output scl, output sda_ctl_oe, input sda);
    modport dev (input scl, output sda_dev_oe, input sda);
endinterface

// ---- logic/twe_sync_edge.sv ----
// Two-flop synchroniser with edge detection for the bus pins
`timescale 1ns/1ps
module twe_sync_edge
    import twe_pkg::*;
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_reset_n,
    // Raw pin
    input wire logic i_pin,
    // Synchronised level and edges
    output logic o_level,
    output logic o_rise,
    output logic o_fall
);
    // ==========================================
    // Synchroniser
    logic meta_reg, meta_next;
    logic sync_reg, sync_next;
    logic last_reg, last_next;

    always_comb
    begin
        meta_next = i_pin;
        sync_next = meta_reg;
        last_next = sync_reg;
    end

    // Idle bus is high, so reset to one avoids false edges
    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            meta_reg <= 1'b1;
            sync_reg <= 1'b1;
            last_reg <= 1'b1;
        end
        else
        begin
            meta_reg <= meta_next;
            sync_reg <= sync_next;
            last_reg <= last_next;
        end
    end

    assign o_level = sync_reg;
    assign o_rise = sync_reg & ~last_reg;
    assign o_fall = ~sync_reg & last_reg;
endmodule

// ---- logic/twe_target.sv ----
// Target end: framing, acknowledge, self-timed write and standby
// Overview of operation
// RULE1 - Sender changes data only while clock low
// RULE2 - Data change with clock high frames
// RULE3 - Falling data, clock high: start condition
// RULE4 - Rising data, clock high: stop condition
// RULE5 - Stop after read enters standby
// RULE6 - Words are eight bits, MSB first
// RULE7 - Target pulls data low on ninth clock
// RULE8 - Standby at power-up and after stop
// RULE9 - Controller recovers bus: nine clocks, start
// RULE10 - Self-timed write at most ten ms
// RULE11 - Ignore bus during self-timed write
// RULE12 - Poll with starts; acknowledge once write done
// RULE13 - Controller releases data during ninth clock
`timescale 1ns/1ps
module twe_target
    import twe_pkg::*;
#(
    parameter int WRITE_COUNT = WRITE_CYCLES
)
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_reset_n,
    // Bus
    twe_bus_if.dev bus,
    // User side: received words
    output logic [7:0] o_rx_data,
    output logic o_rx_valid,
    output logic o_start,
    output logic o_stop,
    // User side: status
    output logic o_standby,
    output logic o_write_busy
);
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_SHIFT = 2'b01,
        ST_ACK = 2'b10,
        ST_WRITE = 2'b11
    } twe_state_t;

    // ==========================================
    // Pin sampling
    logic scl_lvl, scl_rise, scl_fall;
    logic sda_lvl, sda_rise, sda_fall;

    twe_sync_edge u_scl (
        .i_clk(i_clk),
        .i_reset_n(i_reset_n),
        .i_pin(bus.scl),
        .o_level(scl_lvl),
        .o_rise(scl_rise),
        .o_fall(scl_fall)
    );
    twe_sync_edge u_sda (
        .i_clk(i_clk),
        .i_reset_n(i_reset_n),
        .i_pin(bus.sda),
        .o_level(sda_lvl),
        .o_rise(sda_rise),
        .o_fall(sda_fall)
    );

    logic start_det, stop_det;
    assign start_det = scl_lvl & sda_fall; // see RULE2 see RULE3
    assign stop_det = scl_lvl & sda_rise; // see RULE2 see RULE4

    // ==========================================
    // Framing state
    twe_state_t state_reg, state_next;
    logic [3:0] bit_reg, bit_next;
    logic [7:0] shift_reg, shift_next;
    logic [7:0] data_reg, data_next;
    logic valid_reg, valid_next;
    logic start_reg, start_next;
    logic stop_reg, stop_next;
    logic oe_reg, oe_next;
    logic standby_reg, standby_next;
    logic wrote_reg, wrote_next;
    logic read_reg, read_next;
    logic first_reg, first_next;
    logic [23:0] wr_reg, wr_next;

    always_comb
    begin
        state_next = state_reg;
        bit_next = bit_reg;
        shift_next = shift_reg;
        data_next = data_reg;
        valid_next = 1'b0;
        start_next = 1'b0;
        stop_next = 1'b0;
        oe_next = oe_reg;
        standby_next = standby_reg;
        wrote_next = wrote_reg;
        read_next = read_reg;
        first_next = first_reg;
        wr_next = wr_reg;
        case (state_reg)
            ST_IDLE:
            begin
                oe_next = 1'b0;
                if (start_det)
                begin
                    state_next = ST_SHIFT; // see RULE3
                    bit_next = BIT_ZERO;
                    standby_next = 1'b0;
                    start_next = 1'b1;
                    first_next = 1'b1;
                end
            end
            ST_SHIFT:
            begin
                if (start_det)
                begin
                    bit_next = BIT_ZERO; // see RULE3
                    start_next = 1'b1;
                    first_next = 1'b1;
                end
                else if (stop_det)
                begin
                    stop_next = 1'b1;
                    if (wrote_reg && !read_reg)
                    begin
                        // Byte data was taken: begin internal write
                        state_next = ST_WRITE; // see RULE10
                        wr_next = WR_ZERO;
                    end
                    else
                    begin
                        state_next = ST_IDLE;
                        standby_next = 1'b1; // see RULE5 see RULE8
                    end
                    wrote_next = 1'b0;
                    read_next = 1'b0;
                end
                else if (scl_rise)
                begin
                    // Sample on rising clock, data stable high time
                    shift_next = {shift_reg[6:0], sda_lvl}; // see RULE6
                    bit_next = bit_reg + 4'h1;
                end
                else if (scl_fall && bit_reg == ACK_SLOT)
                begin
                    state_next = ST_ACK;
                    oe_next = 1'b1; // see RULE7
                    data_next = shift_reg;
                    valid_next = 1'b1;
                    if (first_reg)
                        read_next = shift_reg[0];
                    else
                        wrote_next = 1'b1;
                    first_next = 1'b0;
                end
            end
            ST_ACK:
            begin
                // Released on the falling edge closing the ninth clock
                if (start_det || stop_det)
                begin
                    oe_next = 1'b0;
                    state_next = ST_SHIFT;
                end
                else if (scl_fall)
                begin
                    oe_next = 1'b0; // see RULE7
                    state_next = ST_SHIFT;
                    bit_next = BIT_ZERO;
                end
            end
            ST_WRITE:
            begin
                // Bus ignored, no acknowledge given
                oe_next = 1'b0; // see RULE11 see RULE12
                if (wr_reg == 24'(WRITE_COUNT - 1))
                begin
                    state_next = ST_IDLE; // see RULE10
                    standby_next = 1'b1; // see RULE8
                end
                else
                    wr_next = wr_reg + WR_ONE;
            end
            default:
                state_next = ST_IDLE;
        endcase
    end

    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            state_reg <= ST_IDLE;
            bit_reg <= BIT_ZERO;
            shift_reg <= 8'h00;
            data_reg <= 8'h00;
            valid_reg <= 1'b0;
            start_reg <= 1'b0;
            stop_reg <= 1'b0;
            oe_reg <= 1'b0;
            standby_reg <= 1'b1; // see RULE8
            wrote_reg <= 1'b0;
            read_reg <= 1'b0;
            first_reg <= 1'b0;
            wr_reg <= WR_ZERO;
        end
        else
        begin
            state_reg <= state_next;
            bit_reg <= bit_next;
            shift_reg <= shift_next;
            data_reg <= data_next;
            valid_reg <= valid_next;
            start_reg <= start_next;
            stop_reg <= stop_next;
            oe_reg <= oe_next;
            standby_reg <= standby_next;
            wrote_reg <= wrote_next;
            read_reg <= read_next;
            first_reg <= first_next;
            wr_reg <= wr_next;
        end
    end

    // Busy status registered separately to keep outputs flop-driven
    logic busy_reg, busy_next;
    always_comb
    begin
        busy_next = (state_next == ST_WRITE);
    end
    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
            busy_reg <= 1'b0;
        else
            busy_reg <= busy_next;
    end

    assign bus.sda_dev_oe = oe_reg;
    assign o_rx_data = data_reg;
    assign o_rx_valid = valid_reg;
    assign o_start = start_reg;
    assign o_stop = stop_reg;
    assign o_standby = standby_reg;
    assign o_write_busy = busy_reg;
endmodule

// ---- logic/twe_controller.sv ----
// Controller end: clock divider, start/stop, words, recovery
`timescale 1ns/1ps
module twe_controller
    import twe_pkg::*;
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_reset_n,
    // Bus
    twe_bus_if.ctl bus,
    // User side: request
    input wire logic i_go,
    input wire logic i_recover,
    input wire logic [7:0] i_data,
    input wire logic i_last,
    // User side: answer
    output logic o_busy,
    output logic o_done,
    output logic o_acked
);
    typedef enum logic [2:0] {
        CS_IDLE = 3'b000,
        CS_START = 3'b001,
        CS_BIT = 3'b010,
        CS_ACK = 3'b011,
        CS_STOP = 3'b100,
        CS_RECOVER = 3'b101
    } twe_cstate_t;

    // ==========================================
    // Sequencer
    twe_cstate_t st_reg, st_next;
    logic [7:0] cnt_reg, cnt_next;
    logic [3:0] bit_reg, bit_next;
    logic [7:0] sh_reg, sh_next;
    logic scl_reg, scl_next;
    logic oe_reg, oe_next;
    logic last_reg, last_next;
    logic done_reg, done_next;
    logic ack_reg, ack_next;
    logic sda_m_reg, sda_s_reg;
    logic tick;
    assign tick = (cnt_reg == CNT_ZERO);

    always_comb
    begin
        st_next = st_reg;
        cnt_next = tick ? HALF_PERIOD : cnt_reg - CNT_ONE;
        bit_next = bit_reg;
        sh_next = sh_reg;
        scl_next = scl_reg;
        oe_next = oe_reg;
        last_next = last_reg;
        done_next = 1'b0;
        ack_next = ack_reg;
        case (st_reg)
            CS_IDLE:
            begin
                cnt_next = HALF_PERIOD;
                if (i_recover)
                begin
                    st_next = CS_RECOVER;
                    oe_next = 1'b0;
                    bit_next = BIT_ZERO;
                end
                else if (i_go)
                begin
                    st_next = CS_START;
                    sh_next = i_data;
                    last_next = i_last;
                end
            end
            CS_START:
                if (tick)
                begin
                    if (!oe_reg)
                        oe_next = 1'b1; // Data falls, clock high, see RULE3
                    else
                    begin
                        scl_next = 1'b0;
                        st_next = CS_BIT;
                        bit_next = BIT_ZERO;
                    end
                end
            CS_BIT:
                if (tick)
                begin
                    if (!scl_reg)
                        scl_next = 1'b1;
                    else
                    begin
                        scl_next = 1'b0;
                        sh_next = {sh_reg[6:0], 1'b0}; // see RULE6
                        if (bit_reg == BIT_LAST)
                        begin
                            st_next = CS_ACK;
                            oe_next = 1'b0; // Release for ninth, see RULE13
                        end
                        bit_next = bit_reg + 4'h1;
                    end
                end
                else if (!scl_reg && cnt_reg == QUARTER_PERIOD)
                    // Mid low time: a change on a clock edge reads as framing
                    oe_next = ~sh_reg[7]; // see RULE1 see RULE6
            CS_ACK:
                if (tick)
                begin
                    if (!scl_reg)
                    begin
                        oe_next = 1'b0;
                        scl_next = 1'b1;
                    end
                    else
                    begin
                        ack_next = ~sda_s_reg;
                        scl_next = 1'b0;
                        st_next = CS_STOP;
                    end
                end
            CS_STOP:
                if (tick)
                begin
                    if (!scl_reg)
                        scl_next = 1'b1;
                    else
                    begin
                        // Data rises while clock high
                        oe_next = 1'b0; // see RULE4
                        st_next = CS_IDLE;
                        done_next = 1'b1;
                    end
                end
                else if (!scl_reg && cnt_reg == QUARTER_PERIOD)
                    // Pull low only once the target has let go of its ack
                    oe_next = 1'b1; // see RULE13
            CS_RECOVER:
                if (tick)
                begin
                    if (!scl_reg)
                        scl_next = 1'b1;
                    else if (sda_s_reg || bit_reg == RECOVER_CYCLES)
                    begin
                        oe_next = 1'b1; // Start then stop, see RULE9
                        st_next = CS_STOP;
                        cnt_next = QUARTER_PERIOD;
                        scl_next = 1'b1;
                    end
                    else
                    begin
                        scl_next = 1'b0;
                        bit_next = bit_reg + 4'h1;
                    end
                end
            default:
                st_next = CS_IDLE;
        endcase
    end

    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            st_reg <= CS_IDLE;
            cnt_reg <= HALF_PERIOD;
            bit_reg <= BIT_ZERO;
            sh_reg <= 8'h00;
            scl_reg <= 1'b1;
            oe_reg <= 1'b0;
            last_reg <= 1'b0;
            done_reg <= 1'b0;
            ack_reg <= 1'b0;
            sda_m_reg <= 1'b1;
            sda_s_reg <= 1'b1;
        end
        else
        begin
            st_reg <= st_next;
            cnt_reg <= cnt_next;
            bit_reg <= bit_next;
            sh_reg <= sh_next;
            scl_reg <= scl_next;
            oe_reg <= oe_next;
            last_reg <= last_next;
            done_reg <= done_next;
            ack_reg <= ack_next;
            sda_m_reg <= bus.sda;
            sda_s_reg <= sda_m_reg;
        end
    end

    logic busy_reg;
    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
            busy_reg <= 1'b0;
        else
            busy_reg <= (st_next != CS_IDLE);
    end

    assign bus.scl = scl_reg;
    assign bus.sda_ctl_oe = oe_reg;
    assign o_busy = busy_reg;
    assign o_done = done_reg;
    assign o_acked = ack_reg;
endmodule

// ---- dv/twe_sva.sv ----
// Wire checks for the two-wire link between controller and target
`timescale 1ns/1ps
module twe_sva
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_reset_n,
    // Bus wires
    input wire logic scl,
    input wire logic sda_ctl_oe,
    input wire logic sda_dev_oe,
    input wire logic sda
);
    // ========
    // Frame tracking
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);
    logic scl_q, sda_q, in_frame_reg, in_frame_next;
    logic [3:0] rise_reg, rise_next, idle_reg, idle_next;
    logic start_ev, stop_ev, scl_up;
    always_comb
    begin
        start_ev = scl && scl_q && sda_q && !sda;
        stop_ev = scl && scl_q && !sda_q && sda;
        scl_up = scl && !scl_q;
        in_frame_next = start_ev | (in_frame_reg & ~stop_ev);
        rise_next = start_ev ? 4'h0 :
            rise_reg + {3'h0, scl_up & in_frame_reg};
        idle_next = start_ev ? 4'h0 :
            idle_reg + {3'h0, scl_up & ~in_frame_reg};
    end
    // Raw wires only: the controller drives from registers, no sync
    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            in_frame_reg <= 1'b0;
            rise_reg <= 4'h0;
            idle_reg <= 4'h0;
        end
        else
        begin
            scl_q <= scl;
            sda_q <= sda;
            in_frame_reg <= in_frame_next;
            rise_reg <= rise_next;
            idle_reg <= idle_next;
        end
    end
    // ========
    // Properties
    property p_dev_stable_high;
        scl && $past(scl) |-> $stable(sda_dev_oe);
    endproperty
    a_dev_stable_high: assert property (p_dev_stable_high)
        else $error("target moved data while clock high");
    // Single-word frames: events only before any clock or one past the ninth
    property p_events_at_word_edge;
        scl && scl_q && (sda != sda_q) |->
            rise_reg == 4'h0 || rise_reg == 4'hA;
    endproperty
    a_events_at_word_edge: assert property (p_events_at_word_edge)
        else $error("framing event inside a word");
    property p_ack_after_eight;
        $rose(sda_dev_oe) |-> rise_reg == 4'h8;
    endproperty
    a_ack_after_eight: assert property (p_ack_after_eight)
        else $error("acknowledge not after eighth bit");
    property p_ack_in_frame;
        $rose(sda_dev_oe) |-> in_frame_reg;
    endproperty
    a_ack_in_frame: assert property (p_ack_in_frame)
        else $error("acknowledge outside a frame");
    property p_ack_len;
        $rose(sda_dev_oe) |-> sda_dev_oe [*8];
    endproperty
    a_ack_len: assert property (p_ack_len)
        else $error("acknowledge too short");
    property p_ack_release;
        $fell(scl) && sda_dev_oe |-> ##[1:6] !sda_dev_oe;
    endproperty
    a_ack_release: assert property (p_ack_release)
        else $error("acknowledge held past ninth clock");
    property p_ctl_release;
        sda_dev_oe |-> !sda_ctl_oe;
    endproperty
    a_ctl_release: assert property (p_ctl_release)
        else $error("controller drove data during acknowledge");
    property p_recover_bound;
        scl_up && !in_frame_reg |-> idle_reg < 4'h9;
    endproperty
    a_recover_bound: assert property (p_recover_bound)
        else $error("more than nine recovery clocks");
    c_ack: cover property ($rose(sda_dev_oe));
    c_stop: cover property (stop_ev);
    c_recover: cover property (scl_up && !in_frame_reg);
endmodule

// ---- dv/tb_two_wire_eeprom_bus_framing.sv ----
// Self-checking bench for the two-wire framing ends
`timescale 1ns/1ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin num_errors++; \
$display("MISMATCH t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module tb_two_wire_eeprom_bus_framing
    import twe_pkg::*;
;
    // ========
    // Signals and instances
    localparam int WC = 600;
    localparam int TIMEOUT = 40000;
    logic i_clk, i_reset_n, go, recover, last, in_recover;
    logic [7:0] data, rx1_data, rx2_data, addr, w;
    logic rx1_valid, rx2_valid, start2, stop2, standby1, standby2;
    logic busy_w1, busy_w2, ctl_busy, ctl_done, ctl_acked, s;
    int num_errors = 0, n_checks = 0, cyc = 0, starts2 = 0, stops2 = 0;
    int n, t0;
    logic [7:0] q_rx1[$], q_rx2[$];
    logic q_ack[$];
    twe_bus_if bus1 ();
    twe_bus_if bus2 ();
    twe_controller twe_controller_i (.i_clk(i_clk), .i_reset_n(i_reset_n),
        .bus(bus1.ctl), .i_go(go), .i_recover(recover), .i_data(data),
        .i_last(last), .o_busy(ctl_busy), .o_done(ctl_done),
        .o_acked(ctl_acked));
    twe_target #(.WRITE_COUNT(WC)) twe_target_i (.i_clk(i_clk),
        .i_reset_n(i_reset_n), .bus(bus1.dev), .o_rx_data(rx1_data),
        .o_rx_valid(rx1_valid), .o_start(), .o_stop(),
        .o_standby(standby1), .o_write_busy(busy_w1));
    // Second target faces the bench, which breaks framing on purpose
    twe_target #(.WRITE_COUNT(WC)) twe_target_2_i (.i_clk(i_clk),
        .i_reset_n(i_reset_n), .bus(bus2.dev), .o_rx_data(rx2_data),
        .o_rx_valid(rx2_valid), .o_start(start2), .o_stop(stop2),
        .o_standby(standby2), .o_write_busy(busy_w2));
    twe_sva twe_sva_i (.i_clk(i_clk), .i_reset_n(i_reset_n),
        .scl(bus1.scl), .sda_ctl_oe(bus1.sda_ctl_oe),
        .sda_dev_oe(bus1.sda_dev_oe), .sda(bus1.sda));
    // ========
    // Clock, watchdog, result monitor
    initial
    begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end
    task automatic final_report();
        $display("checks=%0d mismatches=%0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    always @(posedge i_clk)
    begin
        cyc++;
        if (cyc == TIMEOUT)
        begin
            num_errors++;
            final_report();
        end
    end
    always @(negedge i_clk)
    begin
        if (rx1_valid === 1'b1)
            `CHK(rx1_data, q_rx1.pop_front())
        if (rx2_valid === 1'b1)
            `CHK(rx2_data, q_rx2.pop_front())
        if (ctl_done === 1'b1 && !in_recover)
            `CHK(ctl_acked, q_ack.pop_front())
        starts2 += int'(start2 === 1'b1);
        stops2 += int'(stop2 === 1'b1);
    end
    // ========
    // Bench as controller on the second link, scl period 125 ns
    task automatic clk_bit(input logic oe_lo, input logic oe_hi);
        bus2.scl = 1'b0;
        #31.25 bus2.sda_ctl_oe = oe_lo;
        #31.25 bus2.scl = 1'b1;
        #31.25 s = bus2.sda;
        bus2.sda_ctl_oe = oe_hi;
        #31.25;
    endtask
    task automatic send_word(input logic [7:0] v, input logic exp_ack);
        for (int i = WORD_BITS - 1; i >= 0; i--)
            clk_bit(~v[i], ~v[i]);
        clk_bit(1'b0, 1'b0);
        `CHK(s, exp_ack)
    endtask
    task automatic begin_frame();
        @(posedge i_clk);
        #2 clk_bit(1'b0, 1'b1);
    endtask
    task automatic wait_ctl();
        n = 0;
        @(negedge i_clk);
        while (ctl_busy === 1'b1 && n < 3000)
        begin
            @(negedge i_clk);
            n++;
        end
        repeat (8) @(negedge i_clk);
    endtask
    // ========
    // Main sequence
    initial
    begin
        i_reset_n = 1'b0;
        {go, recover, last, in_recover} = 4'h0;
        data = 8'h00;
        bus2.scl = 1'b1;
        bus2.sda_ctl_oe = 1'b0;
        n = $urandom(21);
        repeat (5) @(negedge i_clk);
        `CHK({standby1, standby2, bus1.scl, bus1.sda}, 4'hF)
        `CHK(ctl_busy, 1'b0)
        repeat (5) @(negedge i_clk);
        i_reset_n = 1'b1;
        $display("test reset done");
        // Controller frames with random words, back to back
        for (int k = 0; k < 4; k++)
        begin
            data = 8'($urandom());
            last = 1'($urandom());
            q_rx1.push_back(data);
            q_ack.push_back(1'b1);
            go = 1'b1;
            @(negedge i_clk);
            go = 1'b0;
            wait_ctl();
            `CHK({standby1, busy_w1}, 2'h2)
        end
        $display("test controller frames done");
        // Restart mid-word, then a write frame of three words
        begin_frame();
        for (int i = 0; i < 3; i++)
            clk_bit(1'b0, 1'b0);
        clk_bit(1'b0, 1'b1);
        addr = 8'($urandom()) & 8'hFE;
        q_rx2.push_back(addr);
        send_word(addr, 1'b0);
        for (int i = 0; i < 2; i++)
        begin
            w = 8'($urandom());
            q_rx2.push_back(w);
            send_word(w, 1'b0);
        end
        clk_bit(1'b1, 1'b0);
        t0 = cyc;
        repeat (4) @(negedge i_clk);
        `CHK(starts2, 2)
        `CHK(stops2, 1)
        `CHK({busy_w2, standby2}, 2'h2)
        $display("test write frame done");
        // Poll while busy: ignored, no acknowledge
        begin_frame();
        send_word(addr, 1'b1);
        clk_bit(1'b1, 1'b0);
        n = 0;
        while (busy_w2 === 1'b1 && n < WC + 20)
        begin
            @(negedge i_clk);
            n++;
        end
        `CHK(busy_w2, 1'b0)
        `CHK(cyc - t0 <= WC + 8, 1'b1)
        `CHK(standby2, 1'b1)
        // Poll after the write with a read address: acknowledged
        begin_frame();
        q_rx2.push_back(addr | 8'h01);
        send_word(addr | 8'h01, 1'b0);
        clk_bit(1'b1, 1'b0);
        repeat (4) @(negedge i_clk);
        `CHK(standby2, 1'b1)
        $display("test polling done");
        // Bus recovery from the controller end
        in_recover = 1'b1;
        recover = 1'b1;
        @(negedge i_clk);
        recover = 1'b0;
        wait_ctl();
        in_recover = 1'b0;
        `CHK({ctl_busy, bus1.sda, standby1}, 3'h3)
        $display("test recovery done");
        final_report();
    end
endmodule
